//--- verilog/spim_pkg.sv
package spim_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_CONTROL_MAIN = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_BUFFER_MODE = 3'h1;
	localparam logic [2:0] ADDR_INTERRUPT_ENABLES = 3'h2;
	localparam logic [2:0] ADDR_INTERRUPT_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_SERIAL_DATA = 3'h4;

	// ----------------------------------------------------------------
	// Field positions, writable masks and reset values
	// ----------------------------------------------------------------
	localparam int CM_ENABLE = 0;
	localparam int CM_SCK_PRESCALE_LO = 1;
	localparam int CM_DOUBLE = 4;
	localparam int CM_MASTER = 5;
	localparam int CM_ORDER = 6;
	localparam int CB_MODE_LO = 0;
	localparam int CB_SEL_DIS = 2;
	localparam int CB_WAIT_RX = 6;
	localparam int CB_BUF_ON = 7;
	localparam int IE_LEGACY = 0;
	localparam int FL_OVF = 0;
	localparam int FL_SEL = 4;
	localparam int FL_EMPTY = 5;
	localparam int FL_TX = 6;
	localparam int FL_RX = 7;
	localparam logic [7:0] CM_MASK = 8'h77;
	localparam logic [7:0] CB_MASK = 8'hc7;
	localparam logic [7:0] IE_MASK = 8'hf1;
	localparam logic [7:0] IE_BUF_MASK = 8'hf0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Serial clock half periods, in peripheral_clock cycles, minus one
	// ----------------------------------------------------------------
	localparam logic [6:0] HALF_DIV4 = 7'h01;
	localparam logic [6:0] HALF_DIV16 = 7'h07;
	localparam logic [6:0] HALF_DIV64 = 7'h1f;
	localparam logic [6:0] HALF_DIV128 = 7'h3f;

	// Synchroniser lanes
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_SS = 3;

	// Whole state of the block, registered as one word
	typedef struct packed {
		logic [7:0] control_main;
		logic [7:0] control_buffer_mode;
		logic [7:0] interrupt_enables;
		logic rx_done_flag;
		logic tx_done_flag;
		logic write_collision_flag;
		logic tx_empty_flag;
		logic select_trigger_flag;
		logic rx_overflow_flag;
		logic if_armed;
		logic wcol_armed;
		logic [7:0] shifter;
		logic [7:0] tx_hold;
		logic tx_full;
		logic [7:0] rx_first;
		logic rx_first_v;
		logic [7:0] rx_second;
		logic rx_second_v;
		logic send_pending;
		logic busy;
		logic [2:0] bit_cnt;
		logic [3:0] half_cnt;
		logic [6:0] div_cnt;
		logic sck_lvl;
		logic out_bit;
		logic sck_oe_n;
		logic mosi_oe_n;
		logic miso_oe_n;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic sck_prev;
		logic [7:0] rd_data;
		logic irq;
	} spim_state_type;

endpackage : spim_pkg

//--- verilog/spim_core.sv
`timescale 1ns/100ps
// Behaviour
// - bit_order_sel 0 shifts MSB first, 1 shifts LSB first.
// - master bit 1 selects master operation, 0 selects slave.
// - master, select honoured, select low: drop master bit, set combined flag.
// - select_line_disable set makes the select input ignored in master mode.
// - master serial clock is peripheral_clock over 4, 16, 64 or 128.
// - sck_double doubles the master serial clock; no effect in slave.
// - block works only while the enable bit is set.
// - buffered_mode_on adds two receive buffers, one transmit buffer, split flags.
// - buffered, wait_for_receive 0: first transfer sends a dummy byte.
// - buffered, wait_for_receive 1: first idle write loads shift register directly.
// - modes 0,1 idle low rising lead; modes 2,3 idle high falling lead.
// - modes 0,2 sample leading edge; modes 1,3 sample trailing edge.
// - buffered: each flag except overflow with its enable raises the request; enables read zero otherwise.
// - unbuffered: legacy_irq_en gates the combined flag onto the request.
// - buffered rx_done_flag follows unread receive data; writing 1 clears it.
// - unbuffered: combined flag sets when a whole byte has shifted.
// - combined flag clears on vector service, or flag read then data access.
// - unbuffered write during a transfer is dropped and sets collision flag.
// - buffered tx_done_flag sets when shifting ends with nothing queued.
// - buffered overflow sets on a third byte with both buffers full.
// - buffered data read returns second buffer, then first moves into second.
module spim_core (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic irq_ack_in,
	output logic irq_out,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n_out,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_n_out,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_n_out,
	input wire logic ss_n_in
);

	spim_pkg::spim_state_type st_q;
	spim_pkg::spim_state_type st_d;
	logic en;
	logic mst;
	logic buffered;
	logic cpol;
	logic cpha;
	logic lsb;
	logic ss_low;
	logic [6:0] half_m1;
	logic lead;
	logic trail;
	logic sample;
	logic setup;
	logic in_bit;
	logic done;
	logic start;
	logic data_rd;
	logic data_wr;
	logic flag_rd;

	// ----------------------------------------------------------------
	// Decoded controls
	// ----------------------------------------------------------------
	assign en = st_q.control_main[spim_pkg::CM_ENABLE];
	assign mst = st_q.control_main[spim_pkg::CM_MASTER];
	assign buffered = st_q.control_buffer_mode[spim_pkg::CB_BUF_ON];
	assign cpha = st_q.control_buffer_mode[spim_pkg::CB_MODE_LO];
	assign cpol = st_q.control_buffer_mode[spim_pkg::CB_MODE_LO + 1];
	assign lsb = st_q.control_main[spim_pkg::CM_ORDER];
	assign ss_low = ~st_q.sync2[spim_pkg::PIN_SS];
	assign data_rd = reg_rd_in && (reg_addr_in == spim_pkg::ADDR_SERIAL_DATA);
	assign data_wr = reg_wr_in && (reg_addr_in == spim_pkg::ADDR_SERIAL_DATA);
	assign flag_rd = reg_rd_in && (reg_addr_in == spim_pkg::ADDR_INTERRUPT_FLAGS);

	// Prescale and double pick the master half period
	always_comb begin
		unique case (st_q.control_main[spim_pkg::CM_SCK_PRESCALE_LO +: 2])
			2'h0: half_m1 = spim_pkg::HALF_DIV4;
			2'h1: half_m1 = spim_pkg::HALF_DIV16;
			2'h2: half_m1 = spim_pkg::HALF_DIV64;
			2'h3: half_m1 = spim_pkg::HALF_DIV128;
		endcase
		if (st_q.control_main[spim_pkg::CM_DOUBLE]) begin
			half_m1 = {1'b0, half_m1[6:1]};
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		lead = 1'b0;
		trail = 1'b0;
		done = 1'b0;
		start = 1'b0;
		st_d.rd_data = 8'h00;
		// Pins cross in through two flops; first stage feeds only the second
		st_d.sync1 = {ss_n_in, miso_in, mosi_in, sck_in};
		st_d.sync2 = st_q.sync1;
		st_d.sck_prev = st_q.sync2[spim_pkg::PIN_SCK];

		// Register reads: answer next cycle, zero where unmapped
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				spim_pkg::ADDR_CONTROL_MAIN: st_d.rd_data = st_q.control_main;
				spim_pkg::ADDR_CONTROL_BUFFER_MODE: st_d.rd_data = st_q.control_buffer_mode;
				spim_pkg::ADDR_INTERRUPT_ENABLES: begin
					st_d.rd_data = st_q.interrupt_enables &
						(buffered ? spim_pkg::IE_MASK : ~spim_pkg::IE_BUF_MASK);
				end
				spim_pkg::ADDR_INTERRUPT_FLAGS: begin
					st_d.rd_data = {st_q.rx_done_flag,
						buffered ? st_q.tx_done_flag : st_q.write_collision_flag,
						buffered & st_q.tx_empty_flag, buffered & st_q.select_trigger_flag,
						3'h0, buffered & st_q.rx_overflow_flag};
					// Arm the read-then-access clear for set flags
					if (!buffered && st_q.rx_done_flag) begin
						st_d.if_armed = 1'b1;
					end
					if (!buffered && st_q.write_collision_flag) begin
						st_d.wcol_armed = 1'b1;
					end
				end
				spim_pkg::ADDR_SERIAL_DATA: st_d.rd_data = st_q.rx_second;
				default: st_d.rd_data = 8'h00;
			endcase
		end

		// Data access completes the two-step clear
		if ((data_rd || data_wr) && !buffered) begin
			if (st_q.if_armed) begin
				st_d.rx_done_flag = 1'b0;
				st_d.if_armed = 1'b0;
			end
			if (st_q.wcol_armed) begin
				st_d.write_collision_flag = 1'b0;
				st_d.wcol_armed = 1'b0;
			end
		end
		if (irq_ack_in && !buffered) begin
			st_d.rx_done_flag = 1'b0;
		end

		// Buffered read pops the receive pair
		if (data_rd && buffered) begin
			st_d.rx_second = st_q.rx_first;
			st_d.rx_second_v = st_q.rx_first_v;
			st_d.rx_first_v = 1'b0;
			st_d.rx_overflow_flag = 1'b0;
			st_d.rx_done_flag = st_q.rx_first_v;
		end

		// Register writes; unused bits masked off
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				spim_pkg::ADDR_CONTROL_MAIN: begin
					st_d.control_main = reg_wdata_in & spim_pkg::CM_MASK;
				end
				spim_pkg::ADDR_CONTROL_BUFFER_MODE: begin
					st_d.control_buffer_mode = reg_wdata_in & spim_pkg::CB_MASK;
				end
				spim_pkg::ADDR_INTERRUPT_ENABLES: begin
					st_d.interrupt_enables = reg_wdata_in & spim_pkg::IE_MASK;
				end
				spim_pkg::ADDR_INTERRUPT_FLAGS: begin
					if (buffered) begin
						if (reg_wdata_in[spim_pkg::FL_RX]) begin
							st_d.rx_done_flag = 1'b0;
						end
						if (reg_wdata_in[spim_pkg::FL_TX]) begin
							st_d.tx_done_flag = 1'b0;
						end
						if (reg_wdata_in[spim_pkg::FL_SEL]) begin
							st_d.select_trigger_flag = 1'b0;
						end
					end
				end
				spim_pkg::ADDR_SERIAL_DATA: begin
					if (!buffered) begin
						if (st_q.busy) begin
							st_d.write_collision_flag = 1'b1;
						end else begin
							st_d.shifter = reg_wdata_in;
							st_d.send_pending = mst;
						end
					end else if (st_q.control_buffer_mode[spim_pkg::CB_WAIT_RX] && en &&
						!st_q.busy && !st_q.tx_full && !st_q.send_pending && !ss_low) begin
						st_d.shifter = reg_wdata_in;
						st_d.send_pending = mst;
					end else if (!st_q.tx_full) begin
						st_d.tx_hold = reg_wdata_in;
						st_d.tx_full = 1'b1;
						st_d.tx_empty_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Serial engine; roles follow the master bit
		in_bit = mst ? st_q.sync2[spim_pkg::PIN_MISO] : st_q.sync2[spim_pkg::PIN_MOSI];
		if (!en) begin
			// Idle and quiet while disabled
			st_d.busy = 1'b0;
			st_d.bit_cnt = 3'h0;
			st_d.half_cnt = 4'h0;
			st_d.div_cnt = 7'h00;
			st_d.sck_lvl = cpol;
		end else if (mst) begin
			if (!st_q.control_buffer_mode[spim_pkg::CB_SEL_DIS] && ss_low) begin
				// Another master took the bus: fall back to slave
				st_d.control_main[spim_pkg::CM_MASTER] = 1'b0;
				st_d.rx_done_flag = 1'b1;
				st_d.select_trigger_flag = buffered;
				st_d.busy = 1'b0;
				st_d.bit_cnt = 3'h0;
				st_d.send_pending = 1'b0;
				st_d.sck_lvl = cpol;
			end else if (!st_q.busy) begin
				st_d.sck_lvl = cpol;
				// Unloaded buffered start shifts out a dummy byte
				start = st_q.send_pending || (buffered && st_q.tx_full &&
					!st_q.control_buffer_mode[spim_pkg::CB_WAIT_RX]);
				if (start) begin
					st_d.busy = 1'b1;
					st_d.send_pending = 1'b0;
					st_d.bit_cnt = 3'h0;
					st_d.half_cnt = 4'h0;
					st_d.div_cnt = 7'h00;
					st_d.out_bit = lsb ? st_q.shifter[0] : st_q.shifter[7];
				end
			end else if (st_q.div_cnt == half_m1) begin
				st_d.div_cnt = 7'h00;
				st_d.sck_lvl = ~st_q.sck_lvl;
				st_d.half_cnt = st_q.half_cnt + 4'h1;
				lead = ~st_q.half_cnt[0];
				trail = st_q.half_cnt[0];
				done = (st_q.half_cnt == 4'hf);
			end else begin
				st_d.div_cnt = st_q.div_cnt + 7'h01;
			end
		end else if (!ss_low) begin
			// Deselected slave drops any partial byte
			st_d.busy = 1'b0;
			st_d.bit_cnt = 3'h0;
		end else begin
			// Leading edge direction set by polarity
			lead = cpol ? (st_q.sck_prev && !st_q.sync2[spim_pkg::PIN_SCK])
				: (!st_q.sck_prev && st_q.sync2[spim_pkg::PIN_SCK]);
			trail = cpol ? (!st_q.sck_prev && st_q.sync2[spim_pkg::PIN_SCK])
				: (st_q.sck_prev && !st_q.sync2[spim_pkg::PIN_SCK]);
			if (st_q.bit_cnt == 3'h0 && !cpha && !lead) begin
				st_d.out_bit = lsb ? st_q.shifter[0] : st_q.shifter[7];
			end
		end

		// Sample and setup edges per phase
		sample = cpha ? trail : lead;
		setup = cpha ? lead : trail;
		if (sample) begin
			st_d.shifter = lsb ? {in_bit, st_q.shifter[7:1]}
				: {st_q.shifter[6:0], in_bit};
			st_d.bit_cnt = st_q.bit_cnt + 3'h1;
			if (!mst) begin
				done = (st_q.bit_cnt == 3'h7);
				st_d.busy = (st_q.bit_cnt != 3'h7);
			end
		end
		if (setup) begin
			st_d.out_bit = lsb ? st_q.shifter[0] : st_q.shifter[7];
		end

		// Byte finished: deliver data, refill transmit side
		if (done) begin
			if (mst) begin
				st_d.busy = 1'b0;
			end
			if (!buffered) begin
				st_d.rx_second = st_d.shifter;
				st_d.rx_done_flag = 1'b1;
			end else begin
				if (!st_d.rx_second_v) begin
					st_d.rx_second = st_d.shifter;
					st_d.rx_second_v = 1'b1;
				end else if (!st_d.rx_first_v) begin
					st_d.rx_first = st_d.shifter;
					st_d.rx_first_v = 1'b1;
				end else begin
					st_d.rx_overflow_flag = 1'b1;
				end
				st_d.rx_done_flag = 1'b1;
				if (st_q.tx_full) begin
					st_d.shifter = st_q.tx_hold;
					st_d.tx_full = 1'b0;
					st_d.tx_empty_flag = 1'b1;
					st_d.send_pending = mst;
				end else begin
					st_d.tx_done_flag = 1'b1;
				end
			end
		end

		// Interrupt request from the next flags
		if (st_d.control_buffer_mode[spim_pkg::CB_BUF_ON]) begin
			st_d.irq = |(st_d.interrupt_enables[7:4] & {st_d.rx_done_flag, st_d.tx_done_flag,
				st_d.tx_empty_flag, st_d.select_trigger_flag});
		end else begin
			st_d.irq = st_d.interrupt_enables[spim_pkg::IE_LEGACY] & st_d.rx_done_flag;
		end

		// Pin drivers; enables are active low
		st_d.sck_oe_n = ~(st_d.control_main[spim_pkg::CM_ENABLE] &
			st_d.control_main[spim_pkg::CM_MASTER]);
		st_d.mosi_oe_n = st_d.sck_oe_n;
		st_d.miso_oe_n = ~(st_d.control_main[spim_pkg::CM_ENABLE] &
			~st_d.control_main[spim_pkg::CM_MASTER] & ~st_q.sync2[spim_pkg::PIN_SS]);
	end

	// ----------------------------------------------------------------
	// State register; clock enable freezes everything
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= '0;
			st_q.sck_oe_n <= 1'b1;
			st_q.mosi_oe_n <= 1'b1;
			st_q.miso_oe_n <= 1'b1;
			st_q.sync1 <= 4'hf;
			st_q.sync2 <= 4'hf;
		end else if (clk_en_in) begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign reg_rdata_out = st_q.rd_data;
	assign irq_out = st_q.irq;
	assign sck_out = st_q.sck_lvl;
	assign sck_oe_n_out = st_q.sck_oe_n;
	assign mosi_out = st_q.out_bit;
	assign mosi_oe_n_out = st_q.mosi_oe_n;
	assign miso_out = st_q.out_bit;
	assign miso_oe_n_out = st_q.miso_oe_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in || !clk_en_in);

	sequence s_flag_seen;
		flag_rd && !buffered && st_q.rx_done_flag && !irq_ack_in;
	endsequence
	sequence s_data_touch;
		data_rd && !done;
	endsequence

	a_flag_then_data: assert property (s_flag_seen ##[1:2] s_data_touch |=> !st_q.rx_done_flag)
		else $error("combined flag survived flag read and data access");
	a_select_fault: assert property (en && mst && ss_low &&
		!st_q.control_buffer_mode[spim_pkg::CB_SEL_DIS] |=> !mst && st_q.rx_done_flag)
		else $error("select fault kept master mode");
	a_sck_idle_level: assert property (en && mst && !st_q.busy && !start |=> sck_out == $past(cpol))
		else $error("serial clock not at idle level");
	a_sck_divider: assert property (en && mst && st_q.busy && st_q.div_cnt != half_m1 &&
		!(!st_q.control_buffer_mode[spim_pkg::CB_SEL_DIS] && ss_low) |=> $stable(sck_out))
		else $error("serial clock toggled inside half period");
	a_disabled_idle: assert property (!en |=> !st_q.busy && (sck_oe_n_out || en))
		else $error("disabled block still active");
	a_write_collision: assert property (data_wr && !buffered && st_q.busy |=>
		st_q.write_collision_flag)
		else $error("collision flag not set");
	a_buffer_pop: assert property (data_rd && buffered |=> reg_rdata_out == $past(st_q.rx_second))
		else $error("buffered read returned wrong byte");
	a_legacy_irq: assert property (!buffered && st_q.interrupt_enables[0] && st_q.rx_done_flag &&
		!reg_wr_in && !irq_ack_in && !data_rd |=> irq_out)
		else $error("legacy request missing");
	a_enables_hidden: assert property (reg_rd_in && reg_addr_in ==
		spim_pkg::ADDR_INTERRUPT_ENABLES && !buffered |=> reg_rdata_out[7:4] == 4'h0)
		else $error("buffer enables visible outside buffer mode");
	a_txdone_clear: assert property (reg_wr_in && reg_addr_in == spim_pkg::ADDR_INTERRUPT_FLAGS &&
		buffered && reg_wdata_in[6] && !done |=> !st_q.tx_done_flag)
		else $error("transfer complete flag not cleared");

endmodule : spim_core

//--- bench/spim_slave_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side serial slave with a predictable answer sequence
// ------------------------------------------------------------
module spim_slave_model (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic [1:0] mode_in,
	input wire logic order_in,
	output logic miso_out,
	output logic done_out,
	output logic [7:0] rx_out
);
	logic sck_q;
	logic [4:0] edge_q;
	logic [7:0] num_q;
	logic [7:0] tx;
	logic [2:0] k;
	logic last_q;
	// Byte n of the answer is 5a + n * 35, so the bench can predict it
	assign tx = 8'h5a + num_q * 8'h35;
	// Setup edges advance the bit shown: trailing for modes 0,2, leading for 1,3
	assign k = mode_in[0] ? 3'((edge_q - 5'h01) >> 1) : 3'(edge_q >> 1);
	// In modes 1,3 the line wanders before the first setup edge, so a stale bit never passes
	assign miso_out = (mode_in[0] && edge_q == 5'h00) ? ~last_q :
		tx[order_in ? k : 3'h7 - k];
	// Edge tracking; a move to the idle level outside a frame is no edge
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sck_q <= 1'b0;
			edge_q <= 5'h00;
			num_q <= 8'h00;
			rx_out <= 8'h00;
			done_out <= 1'b0;
			last_q <= 1'b0;
		end else begin
			sck_q <= sck_in;
			done_out <= 1'b0;
			last_q <= miso_out;
			if (sck_in != sck_q && !(edge_q == 5'h00 && sck_in == mode_in[1])) begin
				if (edge_q[0] == mode_in[0])
					rx_out <= order_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
				edge_q <= (edge_q == 5'h0f) ? 5'h00 : edge_q + 5'h01;
				if (edge_q == 5'h0f) begin
					done_out <= 1'b1;
					num_q <= num_q + 8'h01;
				end
			end
		end
	end
endmodule : spim_slave_model

//--- bench/spim_core_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module spim_core_tb;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [2:0] reg_addr_in = 3'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic irq_ack_in = 1'b0;
	logic ss_n_in = 1'b1;
	logic [7:0] reg_rdata_out;
	logic irq_out, sck_out, sck_oe_n_out, mosi_out, mosi_oe_n_out, miso_out, miso_oe_n_out;
	logic miso_w, m_done;
	logic [7:0] m_rx;
	logic [1:0] mode = 2'h0;
	logic order = 1'b0;
	logic rd_d = 1'b0;
	logic rd_dd = 1'b0;
	logic sck_prev = 1'b0;
	logic [8:0] rd_q[$];
	logic [8:0] byte_q[$];
	int fail_count = 0;
	int checks = 0;
	int nbytes = 0;
	int since = 0;
	int half_meas = 0;
	int toggles = 0;

	// ------------------------------------------------------------
	// Clock, design and far side
	// ------------------------------------------------------------
	initial forever #2.5 ref_clk_in = ~ref_clk_in;
	spim_core dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_ack_in(irq_ack_in),
		.irq_out(irq_out), .sck_in(1'b0), .sck_out(sck_out), .sck_oe_n_out(sck_oe_n_out),
		.mosi_in(1'b0), .mosi_out(mosi_out), .mosi_oe_n_out(mosi_oe_n_out),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out),
		.ss_n_in(ss_n_in));
	spim_slave_model slave (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.sck_in(sck_out), .mosi_in(mosi_out), .mode_in(mode), .order_in(order),
		.miso_out(miso_w), .done_out(m_done), .rx_out(m_rx));

	// ------------------------------------------------------------
	// Monitors: read pipeline, clock half period, received bytes
	// ------------------------------------------------------------
	always @(posedge ref_clk_in) begin
		rd_d <= reg_rd_in;
		rd_dd <= rd_d;
		since <= since + 1;
		sck_prev <= sck_out;
		if (sck_out !== sck_prev) begin
			half_meas <= since;
			since <= 1;
			toggles <= toggles + 1;
		end
		if (m_done === 1'b1 && byte_q.size() > 0) begin
			nbytes <= nbytes + 1;
			if (byte_q[0][8]) `CHK(m_rx, byte_q[0][7:0])
			void'(byte_q.pop_front());
		end
	end
	// Read data stands only in the cycle after the strobe
	always @(negedge ref_clk_in) if (rd_d) begin
		if (rd_q[0][8]) `CHK(reg_rdata_out, rd_q[0][7:0])
		void'(rd_q.pop_front());
	end

	// ------------------------------------------------------------
	// Bus tasks and helpers
	// ------------------------------------------------------------
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] a, input logic [7:0] exp, input bit chk = 1'b1);
		@(posedge ref_clk_in);
		rd_q.push_back({chk, exp});
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
	endtask : rd
	// Bounded wait on the far side's byte count, then let flags settle
	task wait_bytes(input int n);
		for (int i = 0; i < 4000 && nbytes < n; i++) @(posedge ref_clk_in);
		`CHK(nbytes >= n, 1'b1)
		repeat (4) @(posedge ref_clk_in);
	endtask : wait_bytes
	task do_reset;
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
	endtask : do_reset
	function automatic logic [7:0] txb(input int n);
		return 8'h5a + 8'(n) * 8'h35;
	endfunction : txb
	task give_verdict;
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Longest path is about 4k cycles; allow generous slack
	initial begin
		#(5 * 60000);
		fail_count++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [1:0] m;
		logic dbl;
		logic o;
		logic [7:0] b;
		int h;
		int t;
		int nb0;
		void'($urandom(99));
		do_reset();
		// Reset values, writable bits, unmapped offset
		for (int a = 0; a < 6; a++) rd(3'(a), 8'h00);
		wr(spim_pkg::ADDR_CONTROL_MAIN, 8'hff);
		rd(spim_pkg::ADDR_CONTROL_MAIN, 8'h77);
		wr(spim_pkg::ADDR_INTERRUPT_ENABLES, 8'hff);
		rd(spim_pkg::ADDR_INTERRUPT_ENABLES, 8'h01);
		wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'hff);
		rd(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'hc7);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00);
		do_reset();
		// Master transfers in every mode, order and prescale
		wr(spim_pkg::ADDR_INTERRUPT_ENABLES, 8'h01);
		for (int i = 0; i < 8; i++) begin
			m = 2'(i);
			o = (i > 3);
			dbl = 1'($urandom);
			b = 8'($urandom);
			mode <= m;
			order <= o;
			wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, {6'h00, m});
			wr(spim_pkg::ADDR_CONTROL_MAIN, {1'b0, o, 1'b1, dbl, 1'b0, 2'(i), 1'b1});
			repeat (2) @(posedge ref_clk_in);
			`CHK(sck_out, m[1])
			`CHK(sck_oe_n_out, 1'b0)
			byte_q.push_back({1'b1, b});
			wr(spim_pkg::ADDR_SERIAL_DATA, b);
			// Second write lands mid-transfer and must be dropped
			if (i == 0) wr(spim_pkg::ADDR_SERIAL_DATA, ~b);
			wait_bytes(i + 1);
			h = ((i % 4) == 3) ? 64 : (2 << (2 * (i % 4)));
			h = h >> dbl;
			`CHK(half_meas, h)
			`CHK(irq_out, 1'b1)
			if (i == 1) begin
				irq_ack_in <= 1'b1;
				@(posedge ref_clk_in);
				irq_ack_in <= 1'b0;
				rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
			end else
				rd(spim_pkg::ADDR_INTERRUPT_FLAGS, (i == 0) ? 8'hc0 : 8'h80);
			// Two synchroniser flops delay the far side's bits past the fastest half period
			rd(spim_pkg::ADDR_SERIAL_DATA, txb(i), (i % 4) != 0);
			repeat (2) @(posedge ref_clk_in);
			`CHK(irq_out, 1'b0)
			`CHK(sck_out, m[1])
		end
		// Select pulled low in master mode, honoured then ignored
		mode <= 2'h0;
		order <= 1'b0;
		wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'h00);
		wr(spim_pkg::ADDR_CONTROL_MAIN, 8'h21);
		ss_n_in <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		rd(spim_pkg::ADDR_CONTROL_MAIN, 8'h01);
		rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'h80);
		wr(spim_pkg::ADDR_SERIAL_DATA, 8'h00);
		ss_n_in <= 1'b1;
		wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'h04);
		wr(spim_pkg::ADDR_CONTROL_MAIN, 8'h21);
		ss_n_in <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		rd(spim_pkg::ADDR_CONTROL_MAIN, 8'h21);
		rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
		ss_n_in <= 1'b1;
		// Disabled block starts no transfer after a data write
		wr(spim_pkg::ADDR_CONTROL_MAIN, 8'h20);
		t = toggles;
		wr(spim_pkg::ADDR_SERIAL_DATA, 8'h3c);
		repeat (40) @(posedge ref_clk_in);
		`CHK(sck_oe_n_out, 1'b1)
		`CHK(toggles, t)
		rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
		// Buffered mode after a third reset
		do_reset();
		nb0 = nbytes;
		wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'hc0);
		wr(spim_pkg::ADDR_CONTROL_MAIN, 8'h23);
		byte_q.push_back({1'b1, 8'ha1});
		byte_q.push_back({1'b1, 8'hb2});
		wr(spim_pkg::ADDR_SERIAL_DATA, 8'ha1);
		wr(spim_pkg::ADDR_SERIAL_DATA, 8'hb2);
		wait_bytes(nb0 + 2);
		rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'he0);
		wr(spim_pkg::ADDR_INTERRUPT_ENABLES, 8'hf1);
		repeat (2) @(posedge ref_clk_in);
		`CHK(irq_out, 1'b1)
		wr(spim_pkg::ADDR_INTERRUPT_ENABLES, 8'h00);
		repeat (2) @(posedge ref_clk_in);
		`CHK(irq_out, 1'b0)
		wr(spim_pkg::ADDR_CONTROL_BUFFER_MODE, 8'h80);
		byte_q.push_back({1'b0, 8'h00});
		byte_q.push_back({1'b1, 8'hc3});
		wr(spim_pkg::ADDR_SERIAL_DATA, 8'hc3);
		wait_bytes(nb0 + 4);
		rd(spim_pkg::ADDR_INTERRUPT_FLAGS, 8'he1);
		rd(spim_pkg::ADDR_SERIAL_DATA, txb(0));
		rd(spim_pkg::ADDR_SERIAL_DATA, txb(1));
		repeat (4) @(posedge ref_clk_in);
		give_verdict();
	end
endmodule : spim_core_tb
